// file: cbd_pkg.sv
// Constants, register map and carrier types of the clock bank configuration block.
package cbd_pkg;
  // Three-level pin codes; an open pin reads as OPEN and is treated as MID.
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_OPEN = 2'h3;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_PHASE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SKEW = 8'h0C;
  localparam logic [7:0] ADDR_RANGE = 8'h10;

  // Config register field positions.
  localparam int CFG_RANGE_POS = 0;
  localparam int CFG_EDGE_POS = 2;
  localparam int CFG_BYPASS_POS = 4;
  localparam int CFG_GATE_POS = 8;
  localparam logic [15:0] CONFIG_RESET = 16'h0009;
  // Every bank at the zero-skew phase code.
  localparam logic [15:0] PHASE_RESET = 16'h5555;

  // Status register field positions.
  localparam int ST_MF_POS = 0;
  localparam int ST_PLL_POS = 6;
  localparam int ST_DISMODE_POS = 7;
  localparam int ST_NEG_POS = 8;
  localparam int ST_HIGHDRV_POS = 9;
  localparam int ST_EN_POS = 10;
  localparam int ST_DIV3_POS = 14;
  localparam int ST_DIV4_POS = 16;
  localparam int ST_INV4_POS = 18;

  // Multiplication factors per range.
  localparam logic [5:0] MF_LOW = 6'h20;
  localparam logic [5:0] MF_MID = 6'h10;
  localparam logic [5:0] MF_HIGH = 6'h08;

  // Skew time unit and nominal frequencies (10 kHz units) at which it is 1.0 ns.
  localparam int SKEW_UNIT_PS = 1000;
  localparam logic [15:0] FNOM_LOW = 16'h0C35;
  localparam logic [15:0] FNOM_MID = 16'h186A;
  localparam logic [15:0] FNOM_HIGH = 16'h30D4;
  // In this model one time unit is one clock cycle of the 100 ns clock.
  localparam int CLK_PERIOD_PS = 100000;
  localparam int SKEW_UNIT_CYCLES = 1;

  // Divide-by-one range bounds in MHz.
  localparam logic [7:0] RANGE_LOW_MIN = 8'h18;
  localparam logic [7:0] RANGE_LOW_MAX = 8'h32;
  localparam logic [7:0] RANGE_MID_MIN = 8'h30;
  localparam logic [7:0] RANGE_MID_MAX = 8'h64;
  localparam logic [7:0] RANGE_HIGH_MIN = 8'h60;
  localparam logic [7:0] RANGE_HIGH_MAX = 8'hC8;
  // Overall output frequency span in MHz.
  localparam logic [7:0] OUT_FREQ_MIN = 8'h06;
  localparam logic [7:0] OUT_FREQ_MAX = 8'hC8;

  // Phase code indices and skew delay line.
  localparam logic [3:0] PHASE_IDX_LL = 4'h0;
  localparam logic [3:0] PHASE_IDX_MM = 4'h4;
  localparam logic [3:0] PHASE_IDX_HH = 4'h8;
  localparam logic [3:0] SKEW_DELAY_OFFSET = 4'h8;
  localparam int HIST_DEPTH = 16;

  typedef enum logic [1:0] {
    DIV_BY_1 = 2'h0,
    DIV_BY_2 = 2'h1,
    DIV_BY_4 = 2'h3
  } cbd_div_t;

  typedef struct packed {
    cbd_div_t div;
    logic [3:0] delay;
    logic invert;
    logic enable;
    logic idleLevel;
  } cbd_bank_cfg_t;

  typedef struct packed {
    logic [HIST_DEPTH-1:0] hist;
    logic prevTap;
    logic [1:0] divCnt;
    logic out;
  } cbd_bank_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdData;
    logic [15:0] cfgReg;
    logic [15:0] phase;
    logic [7:0] bankOut;
    logic pllActive;
    logic highDrive;
  } cbd_top_state_t;
endpackage

// file: cbd_bank_output.sv
// One output bank: skew delay line, output divider, inversion and disable level.
`timescale 1ns/1ns
module cbd_bank_output (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic refIn,
  input cbd_pkg::cbd_bank_cfg_t bankCfg,
  output logic bankOut
);
  cbd_pkg::cbd_bank_state_t cur;
  cbd_pkg::cbd_bank_state_t next_cur;
  logic tap;
  logic wave;

  always_comb begin
    next_cur = cur;
    tap = cur.hist[bankCfg.delay];
    next_cur.hist = {cur.hist[cbd_pkg::HIST_DEPTH-2:0], refIn};
    next_cur.prevTap = tap;
    if (tap && !cur.prevTap) begin
      next_cur.divCnt = cur.divCnt + 2'h1;
    end
    case (bankCfg.div)
      cbd_pkg::DIV_BY_2: wave = cur.divCnt[0];
      cbd_pkg::DIV_BY_4: wave = cur.divCnt[1];
      default: wave = tap;
    endcase
    // The stop is taken at once, so a disable may shorten the last pulse.
    next_cur.out = bankCfg.enable ? (wave ^ bankCfg.invert) : bankCfg.idleLevel;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign bankOut = cur.out;
endmodule

// file: cbd_clock_bank_config.sv
// Top of the clock bank configuration block with its Wishbone register slave.
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
// Operation
// - Bank 3 divides by 2 for its select LL, by 4 for HH, and by 1 otherwise.
// - Bank 4 divides by 2 for its select LL and by 1 otherwise.
// - Divider select codes that are not divider codes set the bank's phase offset.
// - The range select gives 24-50, 48-100 or 96-200 MHz for low, mid and high.
// - The skew time unit is one over nominal frequency times the factor, 1.0 ns nominal.
// - The multiplication factor is 32 for low range, 16 for mid and 8 for high.
// - Banks 1 and 2 skew from minus four to plus four units for LL to HH, MM zero.
// - Banks 3 and 4 skew in double steps up to six units, LL and HH being special.
// - Bank 4 divides by 2 for LL, inverts for HH, and when inverted idles high unless edge is low.
// - Edge select low means negative edge and low drive, mid positive and high drive.
// - Bypass mid with the gate high keeps the loop running and makes LL a bank disable.
// - In that disable mode every bank not coded LL keeps its skew.
// - Output frequencies span 6 to 200 MHz through range, divider and feedback.
// - Bypass high, or mid with the gate low, stops the loop and routes the reference through unskewed, dividers still in the path.
// - Outside that disable mode the gate high stops all outputs but the two bank 2 outputs, low unless bank 4 is inverted and edge is not low.
// - An open three-level input decodes as the mid setting.
module cbd_clock_bank_config (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic refClk,
  output logic [7:0] bankOut,
  output logic pllActive,
  output logic highDrive
);
  cbd_pkg::cbd_top_state_t cur;
  cbd_pkg::cbd_top_state_t next_cur;
  cbd_pkg::cbd_bank_cfg_t bankCfg [4];
  logic [3:0] bankWave;
  logic [3:0] phaseIdx [4];
  logic [1:0] rangeLvl;
  logic [1:0] edgeLvl;
  logic [1:0] bypassLvl;
  logic gateHigh;
  logic disableMode;
  logic loopOn;
  logic negEdge;
  logic refIn;
  logic [5:0] multFactor;
  logic [15:0] statusWord;
  logic [15:0] skewWord;
  logic [31:0] rangeWord;
  logic [31:0] readMux;
  logic request;

  function automatic logic [1:0] cleanLevel(input logic [1:0] lvl);
    // An open pin sits at mid bias.
    cleanLevel = (lvl == cbd_pkg::LVL_OPEN) ? cbd_pkg::LVL_MID : lvl;
  endfunction

  function automatic logic [3:0] phaseIndex(input logic [3:0] field);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = {2'h0, cleanLevel(field[3:2])};
    lo = {2'h0, cleanLevel(field[1:0])};
    phaseIndex = hi * 4'h3 + lo;
  endfunction

  always_comb begin
    rangeLvl = cleanLevel(cur.cfgReg[cbd_pkg::CFG_RANGE_POS +: 2]);
    edgeLvl = cleanLevel(cur.cfgReg[cbd_pkg::CFG_EDGE_POS +: 2]);
    bypassLvl = cleanLevel(cur.cfgReg[cbd_pkg::CFG_BYPASS_POS +: 2]);
    gateHigh = cur.cfgReg[cbd_pkg::CFG_GATE_POS];
    disableMode = (bypassLvl == cbd_pkg::LVL_MID) && gateHigh;
    loopOn = (bypassLvl == cbd_pkg::LVL_LOW) || disableMode;
    negEdge = (edgeLvl == cbd_pkg::LVL_LOW);
    // Outputs follow the falling reference edge by running on the inverted reference.
    refIn = negEdge ? ~refClk : refClk;
  end

  always_comb begin
    case (rangeLvl)
      cbd_pkg::LVL_LOW: multFactor = cbd_pkg::MF_LOW;
      cbd_pkg::LVL_HIGH: multFactor = cbd_pkg::MF_HIGH;
      default: multFactor = cbd_pkg::MF_MID;
    endcase
  end

  // The range word shows the divide-by-one span and the nominal frequency
  // at which one skew unit is 1.0 ns; outputs reach down to a quarter of it.
  always_comb begin
    case (rangeLvl)
      cbd_pkg::LVL_LOW: begin
        rangeWord = {cbd_pkg::FNOM_LOW, cbd_pkg::RANGE_LOW_MAX, cbd_pkg::RANGE_LOW_MIN};
      end
      cbd_pkg::LVL_HIGH: begin
        rangeWord = {cbd_pkg::FNOM_HIGH, cbd_pkg::RANGE_HIGH_MAX, cbd_pkg::RANGE_HIGH_MIN};
      end
      default: begin
        rangeWord = {cbd_pkg::FNOM_MID, cbd_pkg::RANGE_MID_MAX, cbd_pkg::RANGE_MID_MIN};
      end
    endcase
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      phaseIdx[b] = phaseIndex(cur.phase[4*b +: 4]);
    end
  end

  // Skew is a delay of one clock per time unit around a fixed midpoint, so a lead
  // of six units is still causal; every output carries that midpoint latency.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bankCfg[b].div = cbd_pkg::DIV_BY_1;
      bankCfg[b].invert = 1'b0;
      bankCfg[b].idleLevel = 1'b0;
      bankCfg[b].enable = 1'b1;
      bankCfg[b].delay = cbd_pkg::SKEW_DELAY_OFFSET;
    end
    // Banks 1 and 2 step by one unit from minus four.
    for (int b = 0; b < 2; b++) begin
      bankCfg[b].delay = phaseIdx[b] + cbd_pkg::PHASE_IDX_MM;
    end
    // Banks 3 and 4 step by two units; the end codes pick divider or inversion.
    for (int b = 2; b < 4; b++) begin
      if (phaseIdx[b] != cbd_pkg::PHASE_IDX_LL && phaseIdx[b] != cbd_pkg::PHASE_IDX_HH) begin
        bankCfg[b].delay = {phaseIdx[b][2:0], 1'b0};
      end
    end
    if (phaseIdx[2] == cbd_pkg::PHASE_IDX_LL) begin
      bankCfg[2].div = cbd_pkg::DIV_BY_2;
    end else if (phaseIdx[2] == cbd_pkg::PHASE_IDX_HH) begin
      bankCfg[2].div = cbd_pkg::DIV_BY_4;
    end
    if (phaseIdx[3] == cbd_pkg::PHASE_IDX_LL) begin
      bankCfg[3].div = cbd_pkg::DIV_BY_2;
    end else if (phaseIdx[3] == cbd_pkg::PHASE_IDX_HH) begin
      bankCfg[3].invert = 1'b1;
      // An inverted bank idles high, except with negative-edge sync.
      bankCfg[3].idleLevel = ~negEdge;
    end
    // With the loop off the reference passes unskewed; dividers stay in the path.
    if (!loopOn) begin
      for (int b = 0; b < 4; b++) begin
        bankCfg[b].delay = cbd_pkg::SKEW_DELAY_OFFSET;
      end
    end
    if (disableMode) begin
      for (int b = 0; b < 4; b++) begin
        // Only LL disables; the rest keep their skew.
        bankCfg[b].enable = (phaseIdx[b] != cbd_pkg::PHASE_IDX_LL);
      end
    end else if (gateHigh) begin
      for (int b = 0; b < 4; b++) begin
        // Bank 2 keeps running so it can still close the feedback loop.
        bankCfg[b].enable = (b == 1);
      end
    end
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : gBank
      cbd_bank_output uBank (
        .clk(clk),
        .sys_rst(sys_rst),
        .refIn(refIn),
        .bankCfg(bankCfg[g]),
        .bankOut(bankWave[g])
      );
    end
  endgenerate

  always_comb begin
    statusWord = '0;
    statusWord[cbd_pkg::ST_MF_POS +: 6] = multFactor;
    statusWord[cbd_pkg::ST_PLL_POS] = loopOn;
    statusWord[cbd_pkg::ST_DISMODE_POS] = disableMode;
    statusWord[cbd_pkg::ST_NEG_POS] = negEdge;
    statusWord[cbd_pkg::ST_HIGHDRV_POS] = (edgeLvl == cbd_pkg::LVL_MID);
    for (int b = 0; b < 4; b++) begin
      statusWord[cbd_pkg::ST_EN_POS + b] = bankCfg[b].enable;
    end
    statusWord[cbd_pkg::ST_DIV3_POS +: 2] = bankCfg[2].div;
  end

  always_comb begin
    skewWord = '0;
    for (int b = 0; b < 4; b++) begin
      // Signed skew in time units, two's complement per nibble.
      skewWord[4*b +: 4] = bankCfg[b].delay - cbd_pkg::SKEW_DELAY_OFFSET;
    end
  end

  always_comb begin
    case (wb_adr_i)
      cbd_pkg::ADDR_CONFIG: readMux = {16'h0000, cur.cfgReg};
      cbd_pkg::ADDR_PHASE: readMux = {16'h0000, cur.phase};
      cbd_pkg::ADDR_STATUS: begin
        readMux = {13'h0000, bankCfg[3].invert, bankCfg[3].div, statusWord};
      end
      cbd_pkg::ADDR_SKEW: readMux = {16'h0000, skewWord};
      cbd_pkg::ADDR_RANGE: readMux = rangeWord;
      default: readMux = 32'h00000000;
    endcase
  end

  always_comb begin
    next_cur = cur;
    // One ack per request; the slave drops it the cycle after giving it.
    request = wb_cyc_i && wb_stb_i && !cur.ack;
    next_cur.ack = request;
    if (request) begin
      next_cur.rdData = wb_we_i ? 32'h00000000 : readMux;
    end
    if (request && wb_we_i) begin
      if (wb_adr_i == cbd_pkg::ADDR_CONFIG) begin
        if (wb_sel_i[0]) begin
          next_cur.cfgReg[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          next_cur.cfgReg[15:8] = {7'h00, wb_dat_i[8]};
        end
      end
      if (wb_adr_i == cbd_pkg::ADDR_PHASE) begin
        if (wb_sel_i[0]) begin
          next_cur.phase[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          next_cur.phase[15:8] = wb_dat_i[15:8];
        end
      end
    end
    next_cur.cfgReg[7:6] = 2'h0;
    next_cur.bankOut = {bankWave[3], bankWave[3], bankWave[2], bankWave[2],
                        bankWave[1], bankWave[1], bankWave[0], bankWave[0]};
    next_cur.pllActive = loopOn;
    next_cur.highDrive = (edgeLvl == cbd_pkg::LVL_MID);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '0;
      cur.cfgReg <= cbd_pkg::CONFIG_RESET;
      cur.phase <= cbd_pkg::PHASE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign wb_dat_o = cur.rdData;
  assign wb_ack_o = cur.ack;
  assign bankOut = cur.bankOut;
  assign pllActive = cur.pllActive;
  assign highDrive = cur.highDrive;
endmodule

// file: cbd_clock_bank_config_props.sv
// Port-level checks of the clock bank configuration block.
`timescale 1ns/1ns
module cbd_clock_bank_config_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic refClk,
  input wire logic [7:0] bankOut,
  input wire logic pllActive,
  input wire logic highDrive
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic prevRef;
  logic [4:0] quietCnt;
  logic [3:0] evtHist;
  // Any bus access restarts the quiet count, since a write may reshape the outputs.
  always_ff @(posedge clk) begin
    prevRef <= refClk;
    evtHist <= {evtHist[2:0], sys_rst | (wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o)};
    if (sys_rst || refClk != prevRef || wb_ack_o)
      quietCnt <= 5'h00;
    else if (quietCnt != 5'h1F)
      quietCnt <= quietCnt + 5'h01;
  end
  sequence sTake;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sAckPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_AFTER_TAKE: assert property (sTake |=> sAckPulse)
    else $error("ack did not pulse once after a request");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  AST_WRITE_READS_ZERO: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
    else $error("write answered with nonzero data");
  AST_RESET_QUIET: assert property ($fell(sys_rst) |-> !wb_ack_o && bankOut == 8'h00)
    else $error("outputs not cleared by reset");
  AST_LOOP_AFTER_RESET: assert property ($fell(sys_rst) |=> pllActive && !highDrive)
    else $error("default loop and drive levels wrong");
  AST_BANK_PAIRS: assert property (bankOut[0] == bankOut[1] && bankOut[2] == bankOut[3] &&
    bankOut[4] == bankOut[5] && bankOut[6] == bankOut[7])
    else $error("outputs of one bank differ");
  AST_QUIET_STABLE: assert property (quietCnt >= 5'h18 |-> $stable(bankOut))
    else $error("bank output moved without a reference edge");
  AST_LEVEL_CAUSE: assert property (!$stable({pllActive, highDrive}) |-> |evtHist)
    else $error("loop or drive level moved without a write");
endmodule

// file: cbd_ref_source.sv
// Reference clock source feeding the block, prompt or slow by its half period.
`timescale 1ns/1ns
module cbd_ref_source (
  input wire logic clk,
  input wire logic [5:0] halfCycles,
  output logic refClk
);
  logic [5:0] cnt = 6'h00;
  logic refLvl = 1'b0;
  // Stepping on clk keeps the reference slow enough for the block to sample it.
  always @(posedge clk) begin
    if (cnt + 6'h01 >= halfCycles) begin
      cnt <= 6'h00;
      refLvl <= ~refLvl;
    end else begin
      cnt <= cnt + 6'h01;
    end
  end
  assign refClk = refLvl;
endmodule

// file: cbd_clock_bank_config_test.sv
// Self-checking testbench of the clock bank configuration block.
`timescale 1ns/1ns
module cbd_clock_bank_config_test;
  logic clk, sysRst, wbCyc, wbStb, wbWe, wbAck, refClk, pllActive, highDrive;
  logic [7:0] wbAdr, bankOut, idle, seen, prev, h2;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [5:0] halfCycles;
  int fails, total_checks, toggles, skewBad;
  int r [4];
  logic [15:0] cc [5] = '{16'h0009, 16'h0119, 16'h0129, 16'h0022, 16'h013F};
  logic [15:0] cp [5] = '{16'h5555, 16'h0A50, 16'hA0F1, 16'h8642, 16'hFFFF};
  cbd_clock_bank_config cbd_clock_bank_config_inst (.clk(clk), .sys_rst(sysRst),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .refClk(refClk),
    .bankOut(bankOut), .pllActive(pllActive), .highDrive(highDrive));
  cbd_ref_source cbd_ref_source_inst (.clk(clk), .halfCycles(halfCycles), .refClk(refClk));
  function automatic logic [1:0] lv(input logic [1:0] l);
    return (l == cbd_pkg::LVL_OPEN) ? cbd_pkg::LVL_MID : l;
  endfunction
  function automatic logic [3:0] idx(input logic [3:0] n);
    return 4'(3 * lv(n[3:2]) + lv(n[1:0]));
  endfunction
  function automatic logic [31:0] expStatus(input logic [15:0] c, input logic [15:0] p);
    logic [31:0] s;
    logic dm;
    dm = lv(c[5:4]) == 2'h1 && c[8];
    s = '0;
    s[5:0] = lv(c[1:0]) == 2'h0 ? cbd_pkg::MF_LOW
      : lv(c[1:0]) == 2'h1 ? cbd_pkg::MF_MID : cbd_pkg::MF_HIGH;
    s[6] = lv(c[5:4]) == 2'h0 || dm;
    s[7] = dm;
    s[8] = lv(c[3:2]) == 2'h0;
    s[9] = lv(c[3:2]) == 2'h1;
    for (int b = 0; b < 4; b++) s[10+b] = !c[8] || (dm ? idx(p[4*b+:4]) != 4'h0 : b == 1);
    s[15:14] = idx(p[11:8]) == 4'h0 ? 2'h1 : idx(p[11:8]) == 4'h8 ? 2'h3 : 2'h0;
    s[17:16] = idx(p[15:12]) == 4'h0 ? 2'h1 : 2'h0;
    s[18] = idx(p[15:12]) == 4'h8;
    return s;
  endfunction
  function automatic logic [31:0] expSkew(input logic [31:0] s, input logic [15:0] p);
    logic [31:0] k;
    logic [3:0] i;
    k = '0;
    for (int b = 0; b < 4; b++) begin
      i = idx(p[4*b+:4]);
      if (s[10+b] && b < 2) k[4*b+:4] = i - 4'h4;
      else if (s[10+b] && i != 4'h0 && i != 4'h8) k[4*b+:4] = (i - 4'h4) << 1;
    end
    return s[6] ? k : 32'h0;
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 16);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (wbAck !== 1'b1) begin
      fails++;
      $display("mismatch wb_ack_o expected 1 seen %b", wbAck);
      print_verdict();
    end
  endtask
  task automatic runOne(input logic [31:0] c, input logic [31:0] p);
    logic [31:0] s, m;
    wb(1'b1, cbd_pkg::ADDR_CONFIG, c);
    wb(1'b1, cbd_pkg::ADDR_PHASE, p);
    wb(1'b1, cbd_pkg::ADDR_SKEW, 32'hFFFFFFFF);
    wb(1'b0, cbd_pkg::ADDR_CONFIG, 32'h0);
    check("config", {16'h0, c[15:0] & 16'h013F}, rd);
    wb(1'b0, cbd_pkg::ADDR_PHASE, 32'h0);
    check("phase", {16'h0, p[15:0]}, rd);
    s = expStatus(c[15:0] & 16'h013F, p[15:0]);
    m = '0;
    for (int b = 0; b < 4; b++) m[4*b+:4] = {4{s[10+b]}};
    wb(1'b0, cbd_pkg::ADDR_STATUS, 32'h0);
    check("status", s, rd);
    wb(1'b0, cbd_pkg::ADDR_SKEW, 32'h0);
    check("skew", expSkew(s, p[15:0]), rd & m);
    wb(1'b0, cbd_pkg::ADDR_RANGE, 32'h0);
    check("range", lv(c[1:0]) == 2'h0 ? {cbd_pkg::FNOM_LOW, 16'h3218}
      : lv(c[1:0]) == 2'h1 ? {cbd_pkg::FNOM_MID, 16'h6430} : {cbd_pkg::FNOM_HIGH, 16'hC860}, rd);
    check("levels", {30'h0, s[6], s[9]}, {30'h0, pllActive, highDrive});
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {sysRst, wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} = {4'h8, 8'h00, 32'h0, 4'hF};
    halfCycles = 6'h04;
    fails = 0;
    total_checks = 0;
    void'($urandom(32'h4552));
    repeat (3) @(posedge clk);
    sysRst <= 1'b0;
    for (int t = 0; t < 5; t++) runOne({16'h0, cc[t]}, {16'h0, cp[t]});
    $display("test corners finished");
    for (int t = 0; t < 24; t++) runOne($urandom, $urandom);
    $display("test random finished");
    halfCycles <= 6'h1E;
    for (int e = 0; e < 3; e++) begin
      runOne(32'h0101 | (e << 2), 32'hA555);
      idle = (e == 0) ? 8'h00 : 8'hC0;
      seen = idle;
      toggles = 0;
      repeat (72) begin
        @(posedge clk);
        if ((bankOut & 8'hF3) !== idle) seen = bankOut & 8'hF3;
        toggles += bankOut[2];
      end
      check("stopped", {24'h0, idle}, {24'h0, seen});
      check("bank2 runs", 32'h1, {31'h0, toggles > 0 && toggles < 72});
    end
    $display("test gate finished");
    // Bank 1 at +2 units, bank 2 at -4, bank 3 divided by 4, bank 4 divided by 2.
    runOne(32'h0009, 32'h0A08);
    prev = bankOut;
    h2 = 8'h00;
    skewBad = 0;
    r = '{default: 0};
    // A window of whole reference periods holds an exact count of rising edges.
    for (int n = 0; n < 480; n++) begin
      @(posedge clk);
      for (int b = 0; b < 4; b++) r[b] += bankOut[2*b] & ~prev[2*b];
      if (n >= 8 && bankOut[0] !== h2[5]) skewBad++;
      h2 = {h2[6:0], bankOut[2]};
      prev = bankOut;
    end
    check("bank1 edges", 32'h8, r[0]);
    check("bank2 edges", 32'h8, r[1]);
    check("bank3 edges", 32'h2, r[2]);
    check("bank4 edges", 32'h4, r[3]);
    check("bank1 lag", 32'h0, skewBad);
    $display("test divider finished");
    print_verdict();
  end
endmodule
bind cbd_clock_bank_config cbd_clock_bank_config_props cbd_clock_bank_config_props_inst (
  .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .refClk(refClk), .bankOut(bankOut),
  .pllActive(pllActive), .highDrive(highDrive));
